// [ubst_params.svh]
// constant definitions for the uart baud, sleep and time-out block
`ifndef UBST_PARAMS_SVH
`define UBST_PARAMS_SVH

// register byte addresses
`define UBST_ADDR_DIVLO 4'h0
`define UBST_ADDR_DIVHI 4'h1
`define UBST_ADDR_IER 4'h2
`define UBST_ADDR_LCR 4'h3
`define UBST_ADDR_MCR 4'h4
`define UBST_ADDR_EFR 4'h5
`define UBST_ADDR_SRATE 4'h6
`define UBST_ADDR_STAT 4'h7
`define UBST_ADDR_IIR 4'h8
`define UBST_ADDR_EVT 4'h9

// field positions
`define UBST_IER_SLEEP 4
`define UBST_EFR_ENH 4
`define UBST_LCR_BREAK 6
`define UBST_MCR_PRESC 7
`define UBST_EVT_RXRD 0
`define UBST_EVT_TXWR 1
`define UBST_EVT_CLRTO 2

// reset values and constants
`define UBST_LCR_RESET 8'h1D
`define UBST_BASE_SAMPLES 6'h10
`define UBST_PRESC_LAST 2'h3
`define UBST_TO_CHARS 4'h4
`define UBST_FRAME_BITS 4'hC
`define UBST_IIR_NONE 6'h01
`define UBST_IIR_TIMEOUT 6'h0C
`define UBST_IIR_THR 6'h02
`define UBST_UNMAPPED 32'h0000_0000

`endif

// [ubst_pkg.sv]
// type definitions for the uart baud, sleep and time-out block
package ubst_pkg;
    typedef enum logic [1:0] {
        UBST_RUN = 2'b00,
        UBST_SLEEP = 2'b01
    } ubst_pwr_t;
    typedef logic [7:0] ubst_byte_t;
endpackage

// [ubst_core.sv]
// uart baud generator, sleep control, receive time-out and break logic
//
// Notes on behaviour
// - any low interrupt enable bit set lets a pending source drive the active-low interrupt output
// - low enable bits all zero means polled mode, interrupt output stays high
// - sleep allowed only with enhanced bit 4 and interrupt enable bit 4 set
// - sleep needs idle rx, empty tx fifo and shifter, only tx-holding pending
// - never sleep while the receive fifo holds data
// - asleep, the uart clock enable is stopped
// - wake on rx change, modem input change or host tx fifo write
// - time-out interrupt four character times after last char below trigger
// - time-out counter restarts at stop bit middle and on rx fifo read
// - break when rx stays low longer than one full frame
// - line control bit 6 forces tx low until software clears it
// - divisor runs from 1 to 2^16 minus one
// - prescaler divides by 4 when modem control bit 7 set, by 1 after reset
// - divisor is high byte over low byte
// - samples per bit are 16 minus trim plus add
// - divisor of zero gives no baud clock
// - one generator sets both tx and rx bit rates
// - time-out reported as identification code 00 1100, priority 2; the core puts it above every pending source
`timescale 1ns/1ps
`default_nettype none
`include "ubst_params.svh"

module ubst_core (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // line and modem pins
    input wire logic rx_in,
    input wire logic [3:0] modem_in,
    output logic tx_out,
    // status from the rest of the uart
    input wire logic rx_fifo_nonempty,
    input wire logic rx_below_trigger,
    input wire logic tx_fifo_empty,
    input wire logic tx_shift_empty,
    input wire logic [5:0] pending_irq,
    input wire logic stop_bit_mid,
    // outputs to the rest of the uart
    output logic irq_n,
    output logic uart_clk_en,
    output logic sample_tick,
    output logic bit_tick,
    output logic break_detect,
    output logic [5:0] interrupt_ident_reg
);
    import ubst_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    ubst_byte_t div_low_reg, divisor_high_byte, interrupt_enable_reg;
    ubst_byte_t line_control_reg, modem_control_reg, enhanced_feature_reg;
    logic [3:0] sample_rate_trim, sample_rate_add;
    ubst_pwr_t pwr_reg;
    logic timeout_flag_reg;

    // bus decode; one wait state so every answer comes from a flop
    logic ack_reg;
    wire req = (avs_read | avs_write) & ~ack_reg;
    wire wr = avs_write & ack_reg;
    wire wr_divlo = wr & (avs_address == `UBST_ADDR_DIVLO);
    wire wr_divhi = wr & (avs_address == `UBST_ADDR_DIVHI);
    wire wr_ier = wr & (avs_address == `UBST_ADDR_IER);
    wire wr_lcr = wr & (avs_address == `UBST_ADDR_LCR);
    wire wr_mcr = wr & (avs_address == `UBST_ADDR_MCR);
    wire wr_efr = wr & (avs_address == `UBST_ADDR_EFR);
    wire wr_srate = wr & (avs_address == `UBST_ADDR_SRATE);
    wire wr_evt = wr & (avs_address == `UBST_ADDR_EVT);
    wire ev_rx_read = wr_evt & avs_writedata[`UBST_EVT_RXRD];
    wire ev_tx_write = wr_evt & avs_writedata[`UBST_EVT_TXWR];
    wire ev_clr_to = wr_evt & avs_writedata[`UBST_EVT_CLRTO];

    // ------------------------------------------------------------
    // baud generator
    // ------------------------------------------------------------
    wire [15:0] divisor = {divisor_high_byte, div_low_reg};
    wire div_zero = (divisor == 16'h0000);
    wire presc4 = modem_control_reg[`UBST_MCR_PRESC];
    wire [5:0] samples_per_bit = `UBST_BASE_SAMPLES - {2'b00, sample_rate_trim}
        + {2'b00, sample_rate_add};
    logic [1:0] presc_cnt_reg;
    logic [15:0] div_cnt_reg;
    logic [5:0] samp_cnt_reg;
    wire presc_tick = uart_clk_en & (~presc4 | (presc_cnt_reg == `UBST_PRESC_LAST));
    wire div_roll = presc_tick & ~div_zero & (div_cnt_reg >= divisor - 16'h0001);
    wire samp_roll = div_roll & (samp_cnt_reg >= samples_per_bit - 6'h01);

    // prescaler, divisor and sample counters
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            presc_cnt_reg <= 2'h0;
            div_cnt_reg <= 16'h0000;
            samp_cnt_reg <= 6'h00;
        end else begin
            if (uart_clk_en) presc_cnt_reg <= presc_cnt_reg + 2'h1;
            if (div_zero) div_cnt_reg <= 16'h0000;
            else if (div_roll) div_cnt_reg <= 16'h0000;
            else if (presc_tick) div_cnt_reg <= div_cnt_reg + 16'h0001;
            if (samp_roll) samp_cnt_reg <= 6'h00;
            else if (div_roll) samp_cnt_reg <= samp_cnt_reg + 6'h01;
        end
    end

    // one tick pair feeds both directions
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sample_tick <= 1'b0;
            bit_tick <= 1'b0;
        end else begin
            sample_tick <= div_roll;
            bit_tick <= samp_roll;
        end
    end

    // ------------------------------------------------------------
    // receive time-out and break
    // ------------------------------------------------------------
    logic [3:0] to_bits_reg, to_chars_reg, low_bits_reg, low_chars_reg;
    wire to_restart = stop_bit_mid | ev_rx_read;
    wire char_done = samp_roll & (to_bits_reg == `UBST_FRAME_BITS - 4'h1);
    wire to_fire = char_done & (to_chars_reg == `UBST_TO_CHARS - 4'h1)
        & rx_fifo_nonempty & rx_below_trigger;
    // the first tick after the fall ends a partial bit, so wait for one more
    wire low_char = samp_roll & ~rx_in & (low_bits_reg == `UBST_FRAME_BITS);
    wire rx_idle = rx_in & ~break_detect;

    // time-out counter counts character times while data waits
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            to_bits_reg <= 4'h0;
            to_chars_reg <= 4'h0;
        end else if (to_restart || !rx_fifo_nonempty) begin
            to_bits_reg <= 4'h0;
            to_chars_reg <= 4'h0;
        end else if (samp_roll) begin
            to_bits_reg <= char_done ? 4'h0 : to_bits_reg + 4'h1;
            if (char_done && to_chars_reg != `UBST_TO_CHARS) to_chars_reg <= to_chars_reg + 4'h1;
        end
    end

    // timeout flag: set wins over a read or a clear
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) timeout_flag_reg <= 1'b0;
        else if (to_fire) timeout_flag_reg <= 1'b1;
        else if (ev_rx_read || ev_clr_to || !rx_fifo_nonempty) timeout_flag_reg <= 1'b0;
    end

    // break: low for more than a whole frame of bit times
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            low_bits_reg <= 4'h0;
            low_chars_reg <= 4'h0;
            break_detect <= 1'b0;
        end else if (rx_in) begin
            low_bits_reg <= 4'h0;
            low_chars_reg <= 4'h0;
            break_detect <= 1'b0;
        end else if (samp_roll) begin
            low_bits_reg <= low_char ? 4'h0 : low_bits_reg + 4'h1;
            if (low_char) break_detect <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // sleep control
    // ------------------------------------------------------------
    logic rx_prev_reg;
    logic [3:0] modem_prev_reg;
    wire sleep_en = enhanced_feature_reg[`UBST_EFR_ENH]
        & interrupt_enable_reg[`UBST_IER_SLEEP];
    wire only_thr = (pending_irq == `UBST_IIR_NONE) | (pending_irq == `UBST_IIR_THR);
    wire can_sleep = sleep_en & rx_idle & tx_fifo_empty & tx_shift_empty
        & only_thr & ~timeout_flag_reg & ~rx_fifo_nonempty;
    wire wake = (rx_in != rx_prev_reg) | (modem_in != modem_prev_reg)
        | ev_tx_write;

    // power state; wake wins over a fresh sleep entry
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pwr_reg <= UBST_RUN;
            uart_clk_en <= 1'b1;
            rx_prev_reg <= 1'b1;
            modem_prev_reg <= 4'h0;
        end else begin
            rx_prev_reg <= rx_in;
            modem_prev_reg <= modem_in;
            case (pwr_reg)
                UBST_RUN: begin
                    if (can_sleep && !wake) begin
                        pwr_reg <= UBST_SLEEP;
                        uart_clk_en <= 1'b0;
                    end
                end
                UBST_SLEEP: begin
                    if (wake || !sleep_en) begin
                        pwr_reg <= UBST_RUN;
                        uart_clk_en <= 1'b1;
                    end
                end
                default: begin
                    pwr_reg <= UBST_RUN;
                    uart_clk_en <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // host registers, line and interrupt outputs
    // ------------------------------------------------------------
    // divisor writes during sleep are the host's fault and are not blocked
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            div_low_reg <= 8'h00;
            divisor_high_byte <= 8'h00;
            interrupt_enable_reg <= 8'h00;
            line_control_reg <= `UBST_LCR_RESET;
            modem_control_reg <= 8'h00;
            enhanced_feature_reg <= 8'h00;
            sample_rate_trim <= 4'h0;
            sample_rate_add <= 4'h0;
        end else begin
            if (wr_divlo) div_low_reg <= avs_writedata[7:0];
            if (wr_divhi) divisor_high_byte <= avs_writedata[7:0];
            if (wr_ier) interrupt_enable_reg <= avs_writedata[7:0];
            if (wr_lcr) line_control_reg <= avs_writedata[7:0];
            if (wr_mcr) modem_control_reg <= avs_writedata[7:0];
            if (wr_efr) enhanced_feature_reg <= avs_writedata[7:0];
            if (wr_srate) sample_rate_trim <= avs_writedata[3:0];
            if (wr_srate) sample_rate_add <= avs_writedata[7:4];
        end
    end

    // identification code: time-out sits above tx-holding
    wire [5:0] iir_next = timeout_flag_reg ? `UBST_IIR_TIMEOUT : pending_irq;
    wire irq_on = (|interrupt_enable_reg[3:0]) & (iir_next != `UBST_IIR_NONE);

    // registered pin outputs
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tx_out <= 1'b1;
            irq_n <= 1'b1;
            interrupt_ident_reg <= `UBST_IIR_NONE;
        end else begin
            tx_out <= ~line_control_reg[`UBST_LCR_BREAK];
            irq_n <= ~irq_on;
            interrupt_ident_reg <= iir_next;
        end
    end

    // read mux; unmapped addresses return zero
    logic [31:0] rd_mux;
    assign rd_mux =
        (avs_address == `UBST_ADDR_DIVLO) ? {24'h0, div_low_reg} :
        (avs_address == `UBST_ADDR_DIVHI) ? {24'h0, divisor_high_byte} :
        (avs_address == `UBST_ADDR_IER) ? {24'h0, interrupt_enable_reg} :
        (avs_address == `UBST_ADDR_LCR) ? {24'h0, line_control_reg} :
        (avs_address == `UBST_ADDR_MCR) ? {24'h0, modem_control_reg} :
        (avs_address == `UBST_ADDR_EFR) ? {24'h0, enhanced_feature_reg} :
        (avs_address == `UBST_ADDR_SRATE) ? {24'h0, sample_rate_add, sample_rate_trim} :
        (avs_address == `UBST_ADDR_STAT) ? {26'h0, pwr_reg == UBST_SLEEP, break_detect,
            timeout_flag_reg, rx_idle, div_zero, uart_clk_en} :
        (avs_address == `UBST_ADDR_IIR) ? {26'h0, iir_next} : `UBST_UNMAPPED;

    // avalon handshake: waitrequest low one cycle after request
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ack_reg <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_reg <= req;
            avs_waitrequest <= ~req;
            if (req) avs_readdata <= rd_mux;
        end
    end
endmodule
`default_nettype wire

// [ubst_core_props.sv]
// assertion checker for the baud, sleep and time-out core
`timescale 1ns/1ps
`default_nettype none
`include "ubst_params.svh"
module ubst_core_props (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // register bus
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    // pins and uart status
    input wire logic [3:0] modem_in,
    input wire logic tx_out,
    input wire logic rx_fifo_nonempty,
    input wire logic irq_n,
    input wire logic uart_clk_en,
    input wire logic sample_tick,
    input wire logic bit_tick
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic [7:0] ier_sh, lcr_sh, efr_sh;
    logic [15:0] div_sh;
    logic div_set;
    wire logic wr_ok = avs_write && !avs_waitrequest;
    wire logic sleep_ok = ier_sh[4] && efr_sh[4];
    wire logic div_zero = div_set && (div_sh == 16'h0000);
    // shadow control bytes; divisor resets to zero, but trust it only once its high byte is written
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            {ier_sh, efr_sh, div_sh, div_set} <= 33'h0;
            lcr_sh <= `UBST_LCR_RESET;
        end else if (wr_ok) begin
            case (avs_address)
                `UBST_ADDR_DIVLO: div_sh[7:0] <= avs_writedata[7:0];
                `UBST_ADDR_DIVHI: {div_set, div_sh[15:8]} <= {1'b1, avs_writedata[7:0]};
                `UBST_ADDR_IER: ier_sh <= avs_writedata[7:0];
                `UBST_ADDR_LCR: lcr_sh <= avs_writedata[7:0];
                `UBST_ADDR_EFR: efr_sh <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence s_wake;
        ##[1:8] uart_clk_en;
    endsequence
    property p_one_wait;
        $rose(avs_read || avs_write) |-> ##1 s_answer;
    endproperty
    property p_polled;
        (ier_sh[3:0] == 4'h0) && ($past(ier_sh[3:0], 2) == 4'h0) |-> irq_n;
    endproperty
    property p_break_tx;
        (lcr_sh[6] == $past(lcr_sh[6])) |-> (tx_out == !lcr_sh[6]);
    endproperty
    property p_div_zero;
        div_zero && $past(div_zero) && $past(div_zero, 2) |-> !sample_tick;
    endproperty
    property p_asleep_quiet;
        !uart_clk_en && !$past(uart_clk_en) |-> !sample_tick && !bit_tick;
    endproperty
    property p_rxdata_awake;
        rx_fifo_nonempty && $past(rx_fifo_nonempty, 2) && $past(uart_clk_en) |-> uart_clk_en;
    endproperty
    property p_sleep_gate;
        !sleep_ok && !$past(sleep_ok) && !$past(sleep_ok, 2) |-> uart_clk_en;
    endproperty
    property p_wake;
        !uart_clk_en && $changed(modem_in) |-> s_wake;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("bus answer not after one wait");
    a_polled: assert property (p_polled)
        else $error("interrupt raised in polled mode");
    a_break_tx: assert property (p_break_tx)
        else $error("tx level disagrees with break bit");
    a_div_zero: assert property (p_div_zero)
        else $error("tick with zero divisor");
    a_asleep_quiet: assert property (p_asleep_quiet)
        else $error("tick while asleep");
    a_rxdata_awake: assert property (p_rxdata_awake)
        else $error("slept with receive data held");
    a_sleep_gate: assert property (p_sleep_gate)
        else $error("slept without sleep enable");
    a_wake: assert property (p_wake)
        else $error("no wake on modem change");
endmodule
`default_nettype wire

// [ubst_line_model.sv]
// remote serial station: idles the receive line high, holds it low for a break
`timescale 1ns/1ps
`default_nettype none
module ubst_line_model #(
    parameter int LOW_CLKS = 300
) (
    // clock and bench request
    input wire logic mclk,
    input wire logic brk_go,
    // receive line toward the core
    output logic rx_in
);
    int low_cnt = 0;
    // count the break down; afterwards the line idles high, never a stale level
    always @(posedge mclk) begin
        if (brk_go) begin
            low_cnt <= LOW_CLKS;
        end else if (low_cnt > 0) begin
            low_cnt <= low_cnt - 1;
        end
    end
    assign rx_in = (low_cnt == 0);
endmodule
`default_nettype wire

// [tb_uart_baud_sleep_timeout.sv]
// self-checking bench for the baud, sleep and time-out core
`timescale 1ns/1ps
`default_nettype none
`include "ubst_params.svh"
module tb_uart_baud_sleep_timeout;
    logic mclk, rstn, avs_read, avs_write, rx_in, tx_out, irq_n, uart_clk_en, brk_go;
    logic avs_waitrequest, sample_tick, bit_tick, break_detect, stop_bit_mid;
    logic rx_fifo_nonempty, rx_below_trigger, tx_fifo_empty, tx_shift_empty;
    logic [3:0] avs_address, modem_in;
    logic [31:0] avs_writedata, avs_readdata;
    logic [5:0] pending_irq, interrupt_ident_reg;
    logic [31:0] rd_q[$];
    int err_count = 0;
    int n_tests = 0;
    int n, k, dv, tr, ad, pr;
    // 40 mhz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    ubst_core ubst_core_inst (
        .mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_in(rx_in), .modem_in(modem_in), .tx_out(tx_out),
        .rx_fifo_nonempty(rx_fifo_nonempty), .rx_below_trigger(rx_below_trigger),
        .tx_fifo_empty(tx_fifo_empty), .tx_shift_empty(tx_shift_empty),
        .pending_irq(pending_irq), .stop_bit_mid(stop_bit_mid), .irq_n(irq_n),
        .uart_clk_en(uart_clk_en), .sample_tick(sample_tick), .bit_tick(bit_tick),
        .break_detect(break_detect), .interrupt_ident_reg(interrupt_ident_reg)
    );
    ubst_line_model ubst_line_model_inst (.mclk(mclk), .brk_go(brk_go), .rx_in(rx_in));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // one transfer, held until waitrequest is sampled low; a hang ends the run
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int t;
        t = 0;
        @(posedge mclk);
        {avs_address, avs_writedata, avs_write, avs_read} <= {a, 24'h0, d, w, !w};
        do begin
            @(posedge mclk);
            t++;
        end while (avs_waitrequest !== 1'b0 && t < 50);
        if (t >= 50) begin
            check(32'h1, 32'h0);
            tally_and_finish();
        end
        {avs_write, avs_read} <= 2'h0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        bus(1'b0, a, 8'h00);
    endtask
    // bounded wait for a watched output; must means running out is a failure
    task automatic wait_for(input int w, input logic v, input int lim, input bit must,
        output int cyc);
        logic s;
        cyc = 0;
        do begin
            @(posedge mclk);
            cyc++;
            case (w)
                0: s = sample_tick;
                1: s = bit_tick;
                2: s = uart_clk_en;
                3: s = irq_n;
                4: s = (interrupt_ident_reg === `UBST_IIR_TIMEOUT);
                default: s = break_detect;
            endcase
        end while (s !== v && cyc < lim);
        if (must && s !== v) begin
            check(32'h1, 32'h0);
            tally_and_finish();
        end
    endtask
    // read data pairs with the oldest expectation when the answer is sampled
    always @(posedge mclk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rd_q.size() > 0) begin
            check(avs_readdata, rd_q.pop_front());
        end
    end
    initial begin
        rstn = 1'b0;
        {avs_read, avs_write, rx_fifo_nonempty, rx_below_trigger, stop_bit_mid, brk_go} = 6'h0;
        {tx_fifo_empty, tx_shift_empty, avs_address, modem_in} = 10'h300;
        {avs_writedata, pending_irq} = {32'h0, `UBST_IIR_NONE};
        void'($urandom(8874));
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        rd(`UBST_ADDR_LCR, 32'h0000_001D);
        rd(4'hA, 32'h0000_0000);
        wr(`UBST_ADDR_LCR, 8'h5D);
        repeat (3) @(posedge mclk);
        check(tx_out, 32'h0);
        wr(`UBST_ADDR_LCR, 8'h1D);
        repeat (3) @(posedge mclk);
        check(tx_out, 32'h1);
        // polled versus interrupt mode with a tx-holding source pending
        pending_irq <= `UBST_IIR_THR;
        wait_for(3, 1'b0, 30, 1'b0, n);
        check(n, 32'd30);
        wr(`UBST_ADDR_IER, 8'h0F);
        wait_for(3, 1'b0, 30, 1'b1, n);
        wr(`UBST_ADDR_IER, 8'h00);
        wait_for(3, 1'b1, 30, 1'b1, n);
        // random divisor, trim and add, with both prescaler settings
        for (k = 0; k < 4; k++) begin
            dv = 1 + $urandom % 3;
            tr = $urandom % 4;
            ad = $urandom % 4;
            pr = (k % 2) ? 4 : 1;
            wr(`UBST_ADDR_DIVLO, dv[7:0]);
            wr(`UBST_ADDR_DIVHI, 8'h00);
            wr(`UBST_ADDR_SRATE, {ad[3:0], tr[3:0]});
            wr(`UBST_ADDR_MCR, (k % 2) ? 8'h80 : 8'h00);
            wait_for(1, 1'b1, 4000, 1'b1, n);
            wait_for(0, 1'b1, 4000, 1'b1, n);
            wait_for(0, 1'b1, 4000, 1'b1, n);
            check(n, pr * dv);
            wait_for(1, 1'b1, 4000, 1'b1, n);
            wait_for(1, 1'b1, 4000, 1'b1, n);
            check(n, pr * dv * (16 - tr + ad));
        end
        wr(`UBST_ADDR_MCR, 8'h00);
        wr(`UBST_ADDR_DIVLO, 8'h00);
        wr(`UBST_ADDR_DIVHI, 8'h01);
        wait_for(0, 1'b1, 4000, 1'b1, n);
        wait_for(0, 1'b1, 4000, 1'b1, n);
        check(n, 32'd256);
        wr(`UBST_ADDR_DIVHI, 8'h00);
        repeat (5) @(posedge mclk);
        wait_for(0, 1'b1, 300, 1'b0, n);
        check(n, 32'd300);
        // sixteen clocks per bit: break must wait out a whole frame
        wr(`UBST_ADDR_DIVLO, 8'h01);
        wr(`UBST_ADDR_SRATE, 8'h00);
        brk_go <= 1'b1;
        @(posedge mclk);
        brk_go <= 1'b0;
        wait_for(5, 1'b1, 190, 1'b0, n);
        check(n, 32'd190);
        wait_for(5, 1'b1, 400, 1'b1, n);
        // stale data: a stop bit mid-way restarts the four-character count
        {rx_fifo_nonempty, rx_below_trigger, stop_bit_mid} <= 3'h7;
        @(posedge mclk);
        stop_bit_mid <= 1'b0;
        wait_for(4, 1'b1, 600, 1'b0, n);
        check(n, 32'd600);
        stop_bit_mid <= 1'b1;
        @(posedge mclk);
        stop_bit_mid <= 1'b0;
        wait_for(4, 1'b1, 600, 1'b0, n);
        check(n, 32'd600);
        wait_for(4, 1'b1, 400, 1'b1, n);
        wr(`UBST_ADDR_EVT, 8'h05);
        {rx_fifo_nonempty, rx_below_trigger} <= 2'h2;
        wait_for(4, 1'b0, 20, 1'b1, n);
        // sleep: held receive data blocks it, modem change and tx write wake it
        wr(`UBST_ADDR_EFR, 8'h10);
        wr(`UBST_ADDR_IER, 8'h10);
        wait_for(2, 1'b0, 60, 1'b0, n);
        check(n, 32'd60);
        // a line status source pending must also hold the clock running
        rx_fifo_nonempty <= 1'b0;
        pending_irq <= 6'h06;
        wait_for(2, 1'b0, 30, 1'b0, n);
        check(n, 32'd30);
        pending_irq <= `UBST_IIR_THR;
        wait_for(2, 1'b0, 60, 1'b1, n);
        wait_for(0, 1'b1, 50, 1'b0, n);
        check(n, 32'd50);
        modem_in <= 4'h1;
        wait_for(2, 1'b1, 10, 1'b1, n);
        wait_for(2, 1'b0, 60, 1'b1, n);
        wr(`UBST_ADDR_EVT, 8'h02);
        wait_for(2, 1'b1, 10, 1'b1, n);
        wr(`UBST_ADDR_IER, 8'h00);
        rd(`UBST_ADDR_IIR, {26'h0, `UBST_IIR_THR});
        tally_and_finish();
    end
endmodule
bind ubst_core ubst_core_props ubst_core_props_inst (
    .mclk(mclk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .modem_in(modem_in), .tx_out(tx_out), .rx_fifo_nonempty(rx_fifo_nonempty), .irq_n(irq_n),
    .uart_clk_en(uart_clk_en), .sample_tick(sample_tick), .bit_tick(bit_tick)
);
`default_nettype wire
